// file: core/ppso_cfg.svh
// Offsets, field positions, reset values and event bits of the PLL status bank
`ifndef PPSO_CFG_SVH
`define PPSO_CFG_SVH
`define PPSO_OFS_PLL_STAT  12'h41c
`define PPSO_OFS_CTL_STAT  12'h420
`define PPSO_OFS_FREQ      12'h424
`define PPSO_OFS_IRQ_STAT  12'h430
`define PPSO_OFS_IRQ_MASK  12'h434
`define PPSO_OVR_BIT       31
`define PPSO_SCALE_LSB     29
`define PPSO_FOUR_LSB      24
`define PPSO_FIVE_LSB      22
`define PPSO_INT_LSB       19
`define PPSO_PROP_LSB      16
`define PPSO_TX_LSB        26
`define PPSO_SIGLOSS_LSB   21
`define PPSO_ACCMP_LSB     16
`define PPSO_WORD_LSB      6
`define PPSO_ALIVE_LSB     4
`define PPSO_RST_OVR       1'h0
`define PPSO_RST_SCALE     2'h2
`define PPSO_RST_FOUR      5'h05
`define PPSO_RST_FIVE      2'h1
`define PPSO_RST_INT       3'h0
`define PPSO_RST_PROP      3'h7
`define PPSO_RST_PERIOD    8'h19
`define PPSO_RST_VALID     1'h1
`define PPSO_RST_CTL       32'hc240_ba54
`define PPSO_RST_CPORT     8'h10
`define PPSO_RST_IRQ       4'h0
`define PPSO_EVT_ACK       0
`define PPSO_EVT_DONE      1
`define PPSO_EVT_SUPPLY    2
`define PPSO_EVT_BADDIV    3
`define PPSO_EVT_W         4
`endif

// file: core/ppso_pkg.sv
// Types shared by the PLL status bank modules
package ppso_pkg;
  typedef enum logic [1:0] {
    PPSO_SCALE_NONE   = 2'h0,
    PPSO_SCALE_DOUBLE = 2'h1,
    PPSO_SCALE_HALF   = 2'h2,
    PPSO_SCALE_RSVD   = 2'h3
  } ppso_scale_type;
  typedef logic [7:0] ppso_period_type;
endpackage

// file: core/ppso_div_calc.sv
// Feedback divider period and validity from the two count fields
`timescale 1ns/10ps
`default_nettype none
module ppso_div_calc
  import ppso_pkg::*;
(
  input  wire logic [4:0] four_count,
  input  wire logic [1:0] five_count,
  output logic            [7:0] period,
  output logic                  valid
);
  assign period = ppso_period_type'({1'b0, four_count, 2'b00} + 8'h04 + {6'h00, five_count});
  assign valid = ({3'h0, five_count} <= four_count);
endmodule // ppso_div_calc
`default_nettype wire

// file: core/ppso_irq.sv
// Sticky event status, mask and level interrupt output
`timescale 1ns/10ps
`default_nettype none
`include "ppso_cfg.svh"
module ppso_irq
  import ppso_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic [`PPSO_EVT_W-1:0] evt,
  input  wire logic                  mask_wr,
  input  wire logic [`PPSO_EVT_W-1:0] mask_wdata,
  input  wire logic                  stat_rd,
  output logic       [`PPSO_EVT_W-1:0] stat,
  output logic       [`PPSO_EVT_W-1:0] mask,
  output logic                         irq
);
  logic [`PPSO_EVT_W-1:0] stat_next;
  logic [`PPSO_EVT_W-1:0] mask_next;

  // Read clears, a new event in that cycle still lands
  assign stat_next = (stat_rd ? `PPSO_RST_IRQ : stat) | evt;
  assign mask_next = mask_wr ? mask_wdata : mask;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat <= `PPSO_RST_IRQ;
      mask <= `PPSO_RST_IRQ;
      irq  <= 1'b0;
    end else begin
      stat <= stat_next;
      mask <= mask_next;
      irq  <= |(stat_next & mask_next);
    end
  end
endmodule // ppso_irq
`default_nettype wire

// file: core/ppso_regs.sv
// PLL status, control input status and frequency override register bank
//
// Behaviour
// - Scale select 00 none, 01 double, 10 halve, 11 reserved; resets 10.
// - Divider period is 4*(four count+1)+five count; resets 00101 and 01.
// - Override enable bit 31 makes written PLL fields replace hardware values.
// - Integral pump field 21:19 gives (n+1)/8 current; resets 000.
// - Proportional pump field 18:16 gives (n+1)/8 current; resets 111.
// - Override register bits 3:0 show port request lines; bit 4 reads 1.
// - Bits 5..7 show acknowledge, supply ok, operation complete; 15:8 reserved.
// - Control status register is read-only and follows the control inputs.
// - Transmit, signal loss and comparator levels in bits 30:26, 25:21, 20:16.
// - Word clock select in 8:6, alive clock select in 5:4 resetting 01.
// - Bits 3..0 show spread spectrum, power-on, refclk off, alternate refclk.
// - PLL status bits 15:0 hold the low half of the chip identifier.
`timescale 1ns/10ps
`default_nettype none
`include "ppso_cfg.svh"
module ppso_regs
  import ppso_pkg::*;
#(
  // Arbitrary identifier value
  parameter logic [15:0] CHIP_ID_LOW = 16'h5a5a
)(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  input  wire logic [1:0]  hw_refclk_scale_sel,
  input  wire logic [4:0]  hw_divide_four_count,
  input  wire logic [1:0]  hw_divide_five_count,
  input  wire logic [2:0]  hw_integral_pump_current,
  input  wire logic [2:0]  hw_proportional_pump_current,
  input  wire logic [4:0]  transmit_amplitude_level,
  input  wire logic [4:0]  signal_loss_threshold,
  input  wire logic [4:0]  boundary_ac_comparator_level,
  input  wire logic        fast_technology,
  input  wire logic        low_supply_is_1v2,
  input  wire logic        high_supply_is_3v3,
  input  wire logic        wide_interface,
  input  wire logic        resistor_tune_request,
  input  wire logic [2:0]  word_clock_sel,
  input  wire logic [1:0]  alive_clock_sel,
  input  wire logic        spread_spectrum_enable,
  input  wire logic        pll_power_on,
  input  wire logic        refclk_off,
  input  wire logic        alternate_refclk_sel,
  input  wire logic        config_port_read_request,
  input  wire logic        config_port_write_request,
  input  wire logic        capture_data_request,
  input  wire logic        capture_address_request,
  input  wire logic        config_port_acknowledge,
  input  wire logic        supply_ok,
  input  wire logic        operation_complete,
  output logic      [1:0]  pll_refclk_scale_sel,
  output logic      [4:0]  pll_divide_four_count,
  output logic      [1:0]  pll_divide_five_count,
  output logic      [2:0]  pll_integral_pump_current,
  output logic      [2:0]  pll_proportional_pump_current,
  output logic      [7:0]  pll_divider_period,
  output logic             pll_divider_valid
);

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  logic                   wr_freq;
  logic                   wr_mask;
  logic                   rd_irq_stat;
  logic                   override_enable_reg;
  ppso_scale_type         refclk_scale_sel_reg;
  logic [4:0]             divide_four_count_reg;
  logic [1:0]             divide_five_count_reg;
  logic [2:0]             integral_pump_current_reg;
  logic [2:0]             proportional_pump_current_reg;
  logic [31:0]            ctl_stat_reg;
  logic [31:0]            ctl_stat_next;
  logic [7:0]             cport_reg;
  logic [7:0]             cport_next;
  logic [1:0]             eff_scale;
  logic [4:0]             eff_four;
  logic [1:0]             eff_five;
  logic [2:0]             eff_int;
  logic [2:0]             eff_prop;
  logic [7:0]             eff_period;
  logic                   eff_valid;
  logic                   bad_div_write;
  logic [`PPSO_EVT_W-1:0] evt;
  logic [`PPSO_EVT_W-1:0] irq_stat;
  logic [`PPSO_EVT_W-1:0] irq_mask;
  logic [31:0]            pll_stat_word;
  logic [31:0]            freq_word;
  logic [31:0]            rdata_next;

  assign wr_freq     = reg_wr && (reg_addr == `PPSO_OFS_FREQ);
  assign wr_mask     = reg_wr && (reg_addr == `PPSO_OFS_IRQ_MASK);
  assign rd_irq_stat = reg_rd && (reg_addr == `PPSO_OFS_IRQ_STAT);

  //////////////////////////////////////////////////////////////////////////////
  // Frequency override fields

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      override_enable_reg <= `PPSO_RST_OVR;
    end else if (wr_freq) begin
      override_enable_reg <= reg_wdata[`PPSO_OVR_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      refclk_scale_sel_reg <= ppso_scale_type'(`PPSO_RST_SCALE);
    end else if (wr_freq) begin
      refclk_scale_sel_reg <= ppso_scale_type'(reg_wdata[`PPSO_SCALE_LSB +: 2]);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divide_four_count_reg <= `PPSO_RST_FOUR;
      divide_five_count_reg <= `PPSO_RST_FIVE;
    end else if (wr_freq) begin
      divide_four_count_reg <= reg_wdata[`PPSO_FOUR_LSB +: 5];
      divide_five_count_reg <= reg_wdata[`PPSO_FIVE_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      integral_pump_current_reg     <= `PPSO_RST_INT;
      proportional_pump_current_reg <= `PPSO_RST_PROP;
    end else if (wr_freq) begin
      integral_pump_current_reg     <= reg_wdata[`PPSO_INT_LSB +: 3];
      proportional_pump_current_reg <= reg_wdata[`PPSO_PROP_LSB +: 3];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input snapshots

  assign ctl_stat_next = {1'b1, transmit_amplitude_level, signal_loss_threshold,
                          boundary_ac_comparator_level, 1'b1, fast_technology,
                          low_supply_is_1v2, high_supply_is_3v3, wide_interface,
                          resistor_tune_request, 1'b1, word_clock_sel, alive_clock_sel,
                          spread_spectrum_enable, pll_power_on, refclk_off,
                          alternate_refclk_sel};

  assign cport_next = {operation_complete, supply_ok, config_port_acknowledge, 1'b1,
                       capture_address_request, capture_data_request,
                       config_port_write_request, config_port_read_request};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_stat_reg <= `PPSO_RST_CTL;
      cport_reg    <= `PPSO_RST_CPORT;
    end else begin
      ctl_stat_reg <= ctl_stat_next;
      cport_reg    <= cport_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Settings handed to the PLL

  assign eff_scale = override_enable_reg ? refclk_scale_sel_reg : hw_refclk_scale_sel;
  assign eff_four  = override_enable_reg ? divide_four_count_reg : hw_divide_four_count;
  assign eff_five  = override_enable_reg ? divide_five_count_reg : hw_divide_five_count;
  assign eff_int   = override_enable_reg ? integral_pump_current_reg : hw_integral_pump_current;
  assign eff_prop  = override_enable_reg ? proportional_pump_current_reg
                                         : hw_proportional_pump_current;

  ppso_div_calc u_div_calc (
    .four_count (eff_four),
    .five_count (eff_five),
    .period     (eff_period),
    .valid      (eff_valid)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pll_refclk_scale_sel          <= `PPSO_RST_SCALE;
      pll_divide_four_count         <= `PPSO_RST_FOUR;
      pll_divide_five_count         <= `PPSO_RST_FIVE;
      pll_integral_pump_current     <= `PPSO_RST_INT;
      pll_proportional_pump_current <= `PPSO_RST_PROP;
      pll_divider_period            <= `PPSO_RST_PERIOD;
      pll_divider_valid             <= `PPSO_RST_VALID;
    end else begin
      pll_refclk_scale_sel          <= eff_scale;
      pll_divide_four_count         <= eff_four;
      pll_divide_five_count         <= eff_five;
      pll_integral_pump_current     <= eff_int;
      pll_proportional_pump_current <= eff_prop;
      pll_divider_period            <= eff_period;
      pll_divider_valid             <= eff_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Events and interrupt

  assign bad_div_write = wr_freq && (reg_wdata[`PPSO_FIVE_LSB +: 2] >
                                     reg_wdata[`PPSO_FIVE_LSB + 2 +: 2]) &&
                         (reg_wdata[`PPSO_FOUR_LSB + 2 +: 3] == 3'h0);

  assign evt[`PPSO_EVT_ACK]    = cport_next[5] && !cport_reg[5];
  assign evt[`PPSO_EVT_DONE]   = cport_next[7] && !cport_reg[7];
  assign evt[`PPSO_EVT_SUPPLY] = !cport_next[6] && cport_reg[6];
  assign evt[`PPSO_EVT_BADDIV] = bad_div_write;

  ppso_irq u_irq (
    .clk        (clk),
    .arst_n     (arst_n),
    .evt        (evt),
    .mask_wr    (wr_mask),
    .mask_wdata (reg_wdata[`PPSO_EVT_W-1:0]),
    .stat_rd    (rd_irq_stat),
    .stat       (irq_stat),
    .mask       (irq_mask),
    .irq        (irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  assign pll_stat_word = {1'b1, eff_scale, eff_four, eff_five, eff_int, eff_prop, CHIP_ID_LOW};

  assign freq_word = {override_enable_reg, refclk_scale_sel_reg, divide_four_count_reg,
                      divide_five_count_reg, integral_pump_current_reg,
                      proportional_pump_current_reg, 8'h00, cport_reg};

  always_comb begin
    case (reg_addr)
      `PPSO_OFS_PLL_STAT: rdata_next = pll_stat_word;
      `PPSO_OFS_CTL_STAT: rdata_next = ctl_stat_reg;
      `PPSO_OFS_FREQ:     rdata_next = freq_word;
      `PPSO_OFS_IRQ_STAT: rdata_next = {28'h000_0000, irq_stat};
      `PPSO_OFS_IRQ_MASK: rdata_next = {28'h000_0000, irq_mask};
      default:            rdata_next = 32'h0000_0000;
    endcase
  end

  // Data valid only in the cycle after a read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence read_at(logic [11:0] ofs);
    reg_rd && (reg_addr == ofs);
  endsequence

  sequence write_freq_s;
    wr_freq;
  endsequence

  scale_store_a: assert property (write_freq_s |=> (refclk_scale_sel_reg == $past(reg_wdata[30:29])))
    else $error("scale select not stored");

  div_period_a: assert property (pll_divider_period ==
                                 8'({1'b0, pll_divide_four_count, 2'b00} + 8'h04 +
                                    {6'h00, pll_divide_five_count}))
    else $error("divider period mismatch");

  div_valid_a: assert property (pll_divider_valid ==
                                ({3'h0, pll_divide_five_count} <= pll_divide_four_count))
    else $error("divider validity wrong");

  ovr_source_a: assert property (##1 $past(override_enable_reg) |->
                                 (pll_divide_four_count == $past(divide_four_count_reg)) &&
                                 (pll_refclk_scale_sel == $past(refclk_scale_sel_reg)))
    else $error("override values not applied");

  pump_source_a: assert property (##1 $past(override_enable_reg) |->
                                  (pll_integral_pump_current == $past(integral_pump_current_reg)) &&
                                  (pll_proportional_pump_current ==
                                   $past(proportional_pump_current_reg)))
    else $error("pump settings not applied");

  // Outputs still hold reset values on the edge after release
  hw_default_a: assert property (##1 ($past(arst_n) && !$past(override_enable_reg)) |->
                                 (pll_divide_five_count == $past(hw_divide_five_count)) &&
                                 (pll_integral_pump_current == $past(hw_integral_pump_current)))
    else $error("stored fields leak to PLL");

  port_lines_a: assert property (read_at(`PPSO_OFS_FREQ) ##1 1'b1 |->
                                 (reg_rdata[4] == 1'b1) && (reg_rdata[15:8] == 8'h00) &&
                                 (reg_rdata[3:0] == $past(cport_reg[3:0])) &&
                                 (reg_rdata[7:5] == $past(cport_reg[7:5])))
    else $error("port lines misreported");

  ctl_follow_a: assert property (##2 1'b1 |-> ctl_stat_reg[0] == $past(alternate_refclk_sel))
    else $error("control input not followed");

  // First read after release still returns the reset snapshot
  levels_a: assert property ($past(arst_n) ##0 read_at(`PPSO_OFS_CTL_STAT) ##1 1'b1 |->
                             (reg_rdata[30:26] == $past(transmit_amplitude_level, 2)) &&
                             (reg_rdata[25:21] == $past(signal_loss_threshold, 2)) &&
                             (reg_rdata[20:16] == $past(boundary_ac_comparator_level, 2)))
    else $error("levels misreported");

  clk_sel_a: assert property ($past(arst_n) ##0 read_at(`PPSO_OFS_CTL_STAT) ##1 1'b1 |->
                              (reg_rdata[8:6] == $past(word_clock_sel, 2)) &&
                              (reg_rdata[5:4] == $past(alive_clock_sel, 2)) &&
                              (reg_rdata[3] == $past(spread_spectrum_enable, 2)) &&
                              (reg_rdata[2] == $past(pll_power_on, 2)))
    else $error("clock selects misreported");

  pll_stat_a: assert property (read_at(`PPSO_OFS_PLL_STAT) |=>
                               (reg_rdata[15:0] == CHIP_ID_LOW) && reg_rdata[31] &&
                               (reg_rdata[28:24] == pll_divide_four_count))
    else $error("PLL status word wrong");

  // Read data stands one cycle only
  rdata_idle_a: assert property (!reg_rd |=> (reg_rdata == 32'h0000_0000))
    else $error("read data outside read slot");

  // Interrupt follows unmasked status
  irq_level_a: assert property (irq == |(irq_stat & irq_mask))
    else $error("interrupt level wrong");

endmodule // ppso_regs
`default_nettype wire

// file: testbench/ppso_phy_model.sv
// Far-side analog macro model driving the level, PLL default and port pins
`timescale 1ns/10ps
`default_nettype none
module ppso_phy_model (
  input  wire logic        clk,
  input  wire logic [14:0] hw_cmd,
  input  wire logic [28:0] ctl_cmd,
  input  wire logic [6:0]  port_cmd,
  output logic      [14:0] hw_bus,
  output logic      [28:0] ctl_bus,
  output logic      [6:0]  port_bus
);
  // Pins move one edge after a command, like a synchronised analog side
  always @(posedge clk) begin
    hw_bus <= hw_cmd;
    ctl_bus <= ctl_cmd;
    port_bus <= port_cmd;
  end
endmodule // ppso_phy_model
`default_nettype wire

// file: testbench/ppso_regs_tb.sv
// Register bench for the PLL status and override bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module ppso_regs_tb;
  import ppso_pkg::*;
  // Arbitrary identifier value
  localparam logic [15:0] CHIP = 16'h3c96;
  logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq, pll_divider_valid;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  logic [14:0] hw_cmd = {2'h2, 5'h05, 2'h1, 3'h0, 3'h7}, hw_bus, pll_q;
  logic [28:0] ctl_cmd = 29'h0000_0000, ctl_bus;
  logic [6:0] port_cmd = 7'h00, port_bus;
  logic [1:0] hw_refclk_scale_sel, hw_divide_five_count, alive_clock_sel, pll_refclk_scale_sel, pll_divide_five_count;
  logic [4:0] hw_divide_four_count, transmit_amplitude_level, signal_loss_threshold, boundary_ac_comparator_level;
  logic [4:0] pll_divide_four_count;
  logic [2:0] hw_integral_pump_current, hw_proportional_pump_current, word_clock_sel;
  logic [2:0] pll_integral_pump_current, pll_proportional_pump_current;
  logic [7:0] pll_divider_period;
  logic fast_technology, low_supply_is_1v2, high_supply_is_3v3, wide_interface, resistor_tune_request;
  logic spread_spectrum_enable, pll_power_on, refclk_off, alternate_refclk_sel;
  logic config_port_read_request, config_port_write_request, capture_data_request, capture_address_request;
  logic config_port_acknowledge, supply_ok, operation_complete;
  logic [14:0] tbl [4];
  int n_fail = 0, samples_checked = 0, cyc = 0;
  assign {hw_refclk_scale_sel, hw_divide_four_count, hw_divide_five_count, hw_integral_pump_current,
          hw_proportional_pump_current} = hw_bus;
  assign {transmit_amplitude_level, signal_loss_threshold, boundary_ac_comparator_level, fast_technology,
          low_supply_is_1v2, high_supply_is_3v3, wide_interface, resistor_tune_request, word_clock_sel,
          alive_clock_sel, spread_spectrum_enable, pll_power_on, refclk_off, alternate_refclk_sel} = ctl_bus;
  assign {operation_complete, supply_ok, config_port_acknowledge, capture_address_request, capture_data_request,
          config_port_write_request, config_port_read_request} = port_bus;
  assign pll_q = {pll_refclk_scale_sel, pll_divide_four_count, pll_divide_five_count, pll_integral_pump_current,
                  pll_proportional_pump_current};

  ppso_regs #(.CHIP_ID_LOW(CHIP)) u_dut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .hw_refclk_scale_sel, .hw_divide_four_count, .hw_divide_five_count, .hw_integral_pump_current,
    .hw_proportional_pump_current, .transmit_amplitude_level, .signal_loss_threshold, .boundary_ac_comparator_level,
    .fast_technology, .low_supply_is_1v2, .high_supply_is_3v3, .wide_interface, .resistor_tune_request,
    .word_clock_sel, .alive_clock_sel, .spread_spectrum_enable, .pll_power_on, .refclk_off, .alternate_refclk_sel,
    .config_port_read_request, .config_port_write_request, .capture_data_request, .capture_address_request,
    .config_port_acknowledge, .supply_ok, .operation_complete, .pll_refclk_scale_sel, .pll_divide_four_count,
    .pll_divide_five_count, .pll_integral_pump_current, .pll_proportional_pump_current, .pll_divider_period,
    .pll_divider_valid);
  ppso_phy_model u_phy (.clk, .hw_cmd, .ctl_cmd, .port_cmd, .hw_bus, .ctl_bus, .port_bus);

  initial begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [31:0] pw(input logic t, input logic [14:0] s, input logic [15:0] lo);
    return {t, s, lo};
  endfunction
  function automatic logic [15:0] pb();
    return {8'h00, port_cmd[6:4], 1'b1, port_cmd[3:0]};
  endfunction
  task automatic chk_pll(input logic [14:0] s);
    `CHK("pll_fields", s, pll_q)
    `CHK("pll_period", ((({3'h0, s[12:8]} + 8'h01) * 8'h04) + {6'h00, s[7:6]}), pll_divider_period)
    `CHK("pll_valid", ({3'h0, s[7:6]} <= s[12:8]), pll_divider_valid)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tbl = '{{2'h0, 5'h03, 2'h2, 3'h5, 3'h2}, {2'h1, 5'h1f, 2'h3, 3'h7, 3'h0},
            {2'h2, 5'h00, 2'h0, 3'h1, 3'h6}, {2'h3, 5'h02, 2'h2, 3'h4, 3'h3}};
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk_pll({2'h2, 5'h05, 2'h1, 3'h0, 3'h7});
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(12'h424, d);
    `CHK("freq_rst", 32'h4547_0010, d)
    rd(12'h41c, d);
    `CHK("stat_rst", pw(1'b1, hw_cmd, CHIP), d)
    @(posedge clk);
    @(negedge clk);
    `CHK("rdata_idle", 32'h0000_0000, reg_rdata)
    rd(12'h500, d);
    `CHK("unmapped", 32'h0000_0000, d)
    for (int i = 0; i < 4; i++) begin
      // Legal dividers only: five count never above four count
      wr(12'h424, pw(1'b1, tbl[i], 16'hffff));
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk_pll(tbl[i]);
      rd(12'h424, d);
      `CHK("freq_rb", pw(1'b1, tbl[i], pb()), d)
      wr(12'h41c, 32'h0000_0000);
      rd(12'h41c, d);
      `CHK("stat_ovr", pw(1'b1, tbl[i], CHIP), d)
    end
    hw_cmd <= tbl[0];
    wr(12'h424, pw(1'b0, tbl[1], 16'h0000));
    settle();
    chk_pll(tbl[0]);
    rd(12'h424, d);
    `CHK("freq_kept", pw(1'b0, tbl[1], pb()), d)
    rd(12'h41c, d);
    `CHK("stat_hw", pw(1'b1, tbl[0], CHIP), d)
    for (int k = 0; k < 2; k++) begin
      ctl_cmd <= k ? 29'h1555_5555 : 29'h0aaa_aaaa;
      wr(12'h420, 32'h0000_0000);
      settle();
      rd(12'h420, d);
      `CHK("ctl_stat", {1'b1, ctl_cmd[28:14], 1'b1, ctl_cmd[13:9], 1'b1, ctl_cmd[8:0]}, d)
    end
    // Walk each port line, then check all its events landed
    for (int i = 0; i < 7; i++) begin
      port_cmd <= 7'(1 << i);
      settle();
      rd(12'h424, d);
      `CHK("port_bits", pw(1'b0, tbl[1], pb()), d)
    end
    rd(12'h430, d);
    `CHK("evt_stat", 4'h7, d[3:0])
    rd(12'h430, d);
    `CHK("evt_clr", 4'h0, d[3:0])
    wr(12'h434, 32'h0000_0009);
    // Supply ok rises then drops: masked event only
    port_cmd <= 7'h20;
    settle();
    port_cmd <= 7'h00;
    settle();
    `CHK("irq_masked", 1'b0, irq)
    // Acknowledge and done rise together
    port_cmd <= 7'h50;
    settle();
    `CHK("irq_ack", 1'b1, irq)
    rd(12'h430, d);
    `CHK("evt_ack", 4'h7, d[3:0])
    @(negedge clk);
    `CHK("irq_clr", 1'b0, irq)
    wr(12'h424, pw(1'b1, {2'h0, 5'h02, 2'h3, 3'h0, 3'h0}, 16'h0000));
    settle();
    chk_pll({2'h0, 5'h02, 2'h3, 3'h0, 3'h0});
    `CHK("irq_div", 1'b1, irq)
    rd(12'h430, d);
    `CHK("evt_div", 4'h8, d[3:0])
    rd(12'h434, d);
    `CHK("mask_rb", 4'h9, d[3:0])
    end_sim();
  end
endmodule // ppso_regs_tb
`default_nettype wire
